/* File: rtl/aspect_lamp_defs.svh */
// offsets, field positions, reset values and timing counts of the aspect lamp sequencer
`ifndef ASPECT_LAMP_DEFS_SVH
`define ASPECT_LAMP_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ASL_OFF_SEL 8'h00
`define ASL_OFF_KEY 8'h04
`define ASL_OFF_LAMPS 8'h08
`define ASL_OFF_FX 8'h0c
`define ASL_OFF_FLASH 8'h10
`define ASL_OFF_STATUS 8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ASL_KEY_ADDR_LSB 0
`define ASL_KEY_ADDR_W 11
`define ASL_KEY_ASP_LSB 16
`define ASL_KEY_ASP_W 8
`define ASL_KEY_VALID_BIT 31
`define ASL_SLOT_W 8
`define ASL_SLOT_EN_BIT 7
`define ASL_FX_CODE_W 3
`define ASL_FX_STROBE_LSB 4
`define ASL_STAT_BUSY_BIT 16

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ASL_FLASH_LEN_RST 11'h064

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ASL_CLK_NS 10
`define ASL_TICK_NS 1000000
`define ASL_STROBE_PER_MIN 30
`define ASL_MS_PER_MIN 60000
`define ASL_STROBE_MS (`ASL_MS_PER_MIN / `ASL_STROBE_PER_MIN)
`define ASL_FADE_STEP_MS 16
`define ASL_TUMBLE_HOLD_MS 400
`define ASL_FLICKER_MS 60

`endif

/* File: rtl/aspect_lamp_pkg.sv */
// types shared by the aspect lamp sequencer
package aspect_lamp_pkg;

  typedef enum logic [2:0] {
    FX_NONE,
    FX_FADE,
    FX_TUMBLE,
    FX_SEARCHLIGHT_FILTER_FLASH,
    FX_STROBE
  } effect_e;

  typedef enum logic {
    ST_IDLE,
    ST_INTER
  } seq_state_e;

endpackage

/* File: rtl/aspect_lamp_effect_sequencer.sv */
// aspect command matching, lamp table over apb and lamp transition effects
`timescale 1ns/100ps
`include "aspect_lamp_defs.svh"

module aspect_lamp_effect_sequencer
  import aspect_lamp_pkg::*;
#(
  parameter int TICK_CYCLES = `ASL_TICK_NS / `ASL_CLK_NS,
  parameter int ENTRIES = 8,
  parameter int NUM_LAMPS = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic cmd_valid_i,
  input wire logic [10:0] cmd_addr_i,
  input wire logic [7:0] cmd_aspect_i,
  output logic [NUM_LAMPS-1:0] lamp_o,
  output logic busy_o
);

  localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
  localparam int LW = (NUM_LAMPS > 1) ? $clog2(NUM_LAMPS) : 1;
  localparam logic [3:0] LVL_MAX = 4'hf;
  localparam logic [3:0] SLOT_B = 4'b0010;
  localparam logic [3:0] SLOT_ACD = 4'b1101;
  localparam logic [3:0] SLOT_ALL = 4'b1111;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [IW-1:0] sel_r;
  logic [31:0] key_r [ENTRIES];
  logic [31:0] lamps_r [ENTRIES];
  logic [7:0] fx_r [ENTRIES];
  logic [10:0] flash_len_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_nxt;
  logic [NUM_LAMPS-1:0] target_r;
  logic [IW-1:0] last_r;
  seq_state_e st_r;

  wire setup = psel_i & ~penable_i;
  wire access = psel_i & penable_i;
  wire dec_sel = paddr_i == `ASL_OFF_SEL;
  wire dec_key = paddr_i == `ASL_OFF_KEY;
  wire dec_lamps = paddr_i == `ASL_OFF_LAMPS;
  wire dec_fx = paddr_i == `ASL_OFF_FX;
  wire dec_flash = paddr_i == `ASL_OFF_FLASH;
  wire dec_stat = paddr_i == `ASL_OFF_STATUS;
  wire addr_ok = dec_sel | dec_key | dec_lamps | dec_fx | dec_flash | dec_stat;
  // status is read only, so a write to it is refused like an unmapped one
  wire wr_ok = access & pwrite_i & addr_ok & ~dec_stat;
  wire [31:0] stat_word = {15'h0000, busy_o, 8'(last_r), 8'(target_r)};

  assign pready_o = 1'b1;
  assign pslverr_o = access & (~addr_ok | (pwrite_i & dec_stat));
  assign prdata_o = prdata_r;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (dec_sel) begin
      rd_nxt = 32'(sel_r);
    end else if (dec_key) begin
      rd_nxt = key_r[sel_r];
    end else if (dec_lamps) begin
      rd_nxt = lamps_r[sel_r];
    end else if (dec_fx) begin
      rd_nxt = 32'(fx_r[sel_r]);
    end else if (dec_flash) begin
      rd_nxt = 32'(flash_len_r);
    end else if (dec_stat) begin
      rd_nxt = stat_word;
    end
  end

  // read data is latched in the setup cycle so the zero-wait access sees a flop
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup && !pwrite_i) begin
      prdata_r <= rd_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_r <= '0;
      flash_len_r <= `ASL_FLASH_LEN_RST;
    end else if (wr_ok && dec_sel) begin
      sel_r <= pwdata_i[IW-1:0];
    end else if (wr_ok && dec_flash) begin
      flash_len_r <= pwdata_i[10:0];
    end
  end

  // ----------------------------------------------------------------
  // lamp table and command match
  // ----------------------------------------------------------------
  logic [ENTRIES-1:0] hit;
  logic [IW-1:0] hit_idx;

  for (genvar e = 0; e < ENTRIES; e++) begin : g_entry
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        key_r[e] <= 32'h0000_0000;
        lamps_r[e] <= 32'h0000_0000;
        fx_r[e] <= 8'h00;
      end else if (wr_ok && sel_r == IW'(e)) begin
        if (dec_key) key_r[e] <= pwdata_i;
        if (dec_lamps) lamps_r[e] <= pwdata_i;
        if (dec_fx) fx_r[e] <= pwdata_i[7:0];
      end
    end
    // only the numbers take part; names live in host software
    assign hit[e] = key_r[e][`ASL_KEY_VALID_BIT] &
                    (key_r[e][`ASL_KEY_ADDR_LSB +: `ASL_KEY_ADDR_W] == cmd_addr_i) &
                    (key_r[e][`ASL_KEY_ASP_LSB +: `ASL_KEY_ASP_W] == cmd_aspect_i);
  end

  // lowest matching entry wins when several carry the same key
  always_comb begin
    hit_idx = '0;
    for (int e = ENTRIES - 1; e >= 0; e--) begin
      if (hit[e]) hit_idx = IW'(e);
    end
  end

  function automatic logic [NUM_LAMPS-1:0] slot_mask(input logic [31:0] w, input logic [3:0] use_slot);
    logic [NUM_LAMPS-1:0] m;
    m = '0;
    for (int k = 0; k < 4; k++) begin
      if (use_slot[k] && w[k*`ASL_SLOT_W + `ASL_SLOT_EN_BIT]) begin
        m[w[k*`ASL_SLOT_W +: LW]] = 1'b1;
      end
    end
    return m;
  endfunction

  wire acc = cmd_valid_i & (|hit);
  wire [31:0] ent_lamps = lamps_r[hit_idx];
  wire [7:0] ent_fx = fx_r[hit_idx];
  wire effect_e fx_sel = effect_e'(ent_fx[`ASL_FX_CODE_W-1:0]);
  wire [NUM_LAMPS-1:0] mask_all = slot_mask(ent_lamps, SLOT_ALL);
  wire [NUM_LAMPS-1:0] mask_b = slot_mask(ent_lamps, SLOT_B);
  wire [NUM_LAMPS-1:0] mask_acd = slot_mask(ent_lamps, SLOT_ACD);
  wire [NUM_LAMPS-1:0] mask_strb = slot_mask(ent_lamps, ent_fx[`ASL_FX_STROBE_LSB +: 4]);

  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  logic [16:0] tick_cnt_r;
  logic [4:0] step_cnt_r;
  logic [10:0] strobe_cnt_r;
  logic [3:0] pwm_cnt_r;

  wire ms_tick = tick_cnt_r == 17'(TICK_CYCLES - 1);
  wire step_tick = ms_tick & (step_cnt_r == 5'(`ASL_FADE_STEP_MS - 1));
  wire strobe_on = strobe_cnt_r < flash_len_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_cnt_r <= 17'h00000;
      pwm_cnt_r <= 4'h0;
    end else begin
      tick_cnt_r <= ms_tick ? 17'h00000 : tick_cnt_r + 17'h00001;
      pwm_cnt_r <= pwm_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      step_cnt_r <= 5'h00;
      strobe_cnt_r <= 11'h000;
    end else if (ms_tick) begin
      step_cnt_r <= step_tick ? 5'h00 : step_cnt_r + 5'h01;
      strobe_cnt_r <= (strobe_cnt_r == 11'(`ASL_STROBE_MS - 1)) ? 11'h000 : strobe_cnt_r + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // transition sequencer
  // ----------------------------------------------------------------
  logic fade_r;
  logic [NUM_LAMPS-1:0] final_r;
  logic [NUM_LAMPS-1:0] strobe_mask_r;
  logic [9:0] hold_r;

  wire hold_done = (st_r == ST_INTER) & ms_tick & (hold_r == 10'h000);
  assign busy_o = st_r == ST_INTER;

  // a new command overrides an unfinished intermediate step
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= ST_IDLE;
      target_r <= '0;
      final_r <= '0;
      fade_r <= 1'b0;
      strobe_mask_r <= '0;
      hold_r <= 10'h000;
      last_r <= '0;
    end else if (acc) begin
      last_r <= hit_idx;
      final_r <= mask_acd;
      strobe_mask_r <= '0;
      case (fx_sel)
        FX_FADE: begin
          target_r <= mask_all;
          fade_r <= 1'b1;
          st_r <= ST_IDLE;
        end
        FX_TUMBLE: begin
          target_r <= mask_b;
          fade_r <= 1'b1;
          hold_r <= 10'(`ASL_TUMBLE_HOLD_MS);
          st_r <= ST_INTER;
        end
        FX_SEARCHLIGHT_FILTER_FLASH: begin
          target_r <= mask_b;
          fade_r <= 1'b0;
          hold_r <= 10'(`ASL_FLICKER_MS);
          st_r <= ST_INTER;
        end
        FX_STROBE: begin
          target_r <= mask_all;
          fade_r <= 1'b0;
          strobe_mask_r <= mask_strb;
          st_r <= ST_IDLE;
        end
        default: begin
          target_r <= mask_all;
          fade_r <= 1'b0;
          st_r <= ST_IDLE;
        end
      endcase
    end else if (hold_done) begin
      target_r <= final_r;
      st_r <= ST_IDLE;
    end else if (st_r == ST_INTER && ms_tick) begin
      hold_r <= hold_r - 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // per lamp brightness and pwm
  // ----------------------------------------------------------------
  logic [3:0] level_r [NUM_LAMPS];
  logic [NUM_LAMPS-1:0] lamp_r;
  logic [NUM_LAMPS-1:0] lvl_on;
  logic [NUM_LAMPS-1:0] lvl_off;
  logic [4*NUM_LAMPS-1:0] lvl_flat;
  wire [NUM_LAMPS-1:0] strobe_gate = strobe_mask_r & ~{NUM_LAMPS{strobe_on}};

  for (genvar i = 0; i < NUM_LAMPS; i++) begin : g_lamp
    // without fade the level jumps; with fade one duty step per step tick
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        level_r[i] <= 4'h0;
      end else if (!fade_r) begin
        level_r[i] <= target_r[i] ? LVL_MAX : 4'h0;
      end else if (step_tick && target_r[i] && level_r[i] != LVL_MAX) begin
        level_r[i] <= level_r[i] + 4'h1;
      end else if (step_tick && !target_r[i] && level_r[i] != 4'h0) begin
        level_r[i] <= level_r[i] - 4'h1;
      end
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        lamp_r[i] <= 1'b0;
      end else begin
        lamp_r[i] <= ((level_r[i] == LVL_MAX) | (pwm_cnt_r < level_r[i])) & ~strobe_gate[i];
      end
    end
    assign lvl_on[i] = level_r[i] == LVL_MAX;
    assign lvl_off[i] = level_r[i] == 4'h0;
    assign lvl_flat[4*i +: 4] = level_r[i];
  end

  assign lamp_o = lamp_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_match_only_key: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cmd_valid_i && !(|hit) && st_r == ST_IDLE) |=> $stable(target_r) && $stable(last_r))
    else $error("unmatched command changed the lamp target");

  chk_none_instant: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (acc && !(fx_sel inside {FX_FADE, FX_TUMBLE, FX_SEARCHLIGHT_FILTER_FLASH, FX_STROBE})) ##1 !acc |=>
    (lvl_on == target_r) && (lvl_off == ~target_r))
    else $error("no-effect change left intermediate levels");

  chk_fade_ramp: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ($past(fade_r) && !$past(step_tick)) |-> $stable(lvl_flat))
    else $error("fade level moved off the step tick");

  chk_tumble_inter: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (acc && fx_sel == FX_TUMBLE) |=> (target_r == $past(mask_b)) && (st_r == ST_INTER))
    else $error("tumble-down did not show slot b first");

  chk_tumble_fade: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (acc && fx_sel == FX_TUMBLE) |=> fade_r)
    else $error("tumble-down without cross fade");

  chk_flash_inter: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (acc && fx_sel == FX_SEARCHLIGHT_FILTER_FLASH) |=> (target_r == $past(mask_b)) && !fade_r && busy_o)
    else $error("filter flash did not light slot b at once");

  chk_final_slots: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (hold_done && !acc) |=> (target_r == $past(final_r)) && (st_r == ST_IDLE))
    else $error("intermediate step did not settle on final lamps");

  chk_strobe_rate: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ms_tick && strobe_cnt_r == 11'(`ASL_STROBE_MS - 1)) |=> strobe_cnt_r == 11'h000)
    else $error("strobe period is not thirty per minute");

  chk_strobe_len: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (strobe_gate != '0) |=> (lamp_r & $past(strobe_gate)) == '0)
    else $error("strobe lamp lit outside its flash length");

  chk_any_slot: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (acc && fx_sel == FX_FADE) |=> target_r == $past(mask_all))
    else $error("slot lamps not mapped to their outputs");

endmodule // aspect_lamp_effect_sequencer

/* File: tb/cmd_source_model.sv */
// command source model: sends one aspect command pulse per mast change
`timescale 1ns/100ps
module cmd_source_model (
  input wire logic clk_i,
  output logic cmd_valid_o,
  output logic [10:0] cmd_addr_o,
  output logic [7:0] cmd_aspect_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_addr_o = 11'h000;
    cmd_aspect_o = 8'h00;
  end
  // ----------------------------------------------------------------
  // one command per change
  // ----------------------------------------------------------------
  // each call is one head, so effects never mix heads
  task automatic send(input logic [10:0] a, input logic [7:0] s);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_addr_o <= a;
    cmd_aspect_o <= s;
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    // inverted leftovers so a design that samples late sees garbage
    cmd_addr_o <= ~a;
    cmd_aspect_o <= ~s;
  endtask
endmodule // cmd_source_model

/* File: tb/testbench.sv */
// self-checking bench of the aspect lamp sequencer
`timescale 1ns/100ps
`include "aspect_lamp_defs.svh"
module testbench;
  import aspect_lamp_pkg::*;
  // short timebase keeps the 2 s strobe period affordable
  localparam int TK = 4;
  localparam int PER = `ASL_STROBE_MS * TK;
  logic clk_i;
  logic nrst_i;
  logic psel_i;
  logic penable_i;
  logic pwrite_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic cmd_valid_i;
  logic [10:0] cmd_addr_i;
  logic [7:0] cmd_aspect_i;
  logic [15:0] lamp_o;
  logic busy_o;
  logic [31:0] rd;
  logic err;
  int miscompares;
  int n_tests;
  int c5;
  int c7;
  int cs;

  aspect_lamp_effect_sequencer #(.TICK_CYCLES(TK)) aspect_lamp_effect_sequencer_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .cmd_valid_i(cmd_valid_i),
    .cmd_addr_i(cmd_addr_i), .cmd_aspect_i(cmd_aspect_i), .lamp_o(lamp_o), .busy_o(busy_o));
  cmd_source_model cmd_source_model_inst (
    .clk_i(clk_i), .cmd_valid_o(cmd_valid_i), .cmd_addr_o(cmd_addr_i), .cmd_aspect_o(cmd_aspect_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n == 50) chk("pready", 32'h0, 32'h1);
  endtask
  task automatic prog(input logic [2:0] i, input logic [10:0] a, input logic [7:0] s,
                      input logic [31:0] l, input logic [7:0] fx);
    apb(1'b1, `ASL_OFF_SEL, {29'h0, i});
    apb(1'b1, `ASL_OFF_KEY, {1'b1, 7'h00, s, 5'h00, a});
    apb(1'b1, `ASL_OFF_LAMPS, l);
    apb(1'b1, `ASL_OFF_FX, {24'h0, fx});
  endtask
  task automatic strobe_count(input int exp);
    cs = 0;
    repeat (2 * PER) begin
      @(posedge clk_i);
      #1;
      cs += int'(lamp_o[6]);
    end
    chk("strobe on cycles", cs, exp);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    nrst_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    miscompares = 0;
    n_tests = 0;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    apb(1'b0, `ASL_OFF_FLASH, 32'h0);
    chk("flash reset", rd, {21'h0, `ASL_FLASH_LEN_RST});
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, `ASL_OFF_STATUS, 32'hffffffff);
    chk("status write err", 32'(err), 32'h1);
    apb(1'b0, `ASL_OFF_STATUS, 32'h0);
    chk("status reset", rd, 32'h0);
    // lamps sit in varied slots and indices
    prog(3'h0, 11'h009, 8'h1d, 32'h00000083, 8'h00);
    prog(3'h1, 11'h009, 8'h00, 32'h85000000, 8'h00);
    prog(3'h2, 11'h009, 8'h15, 32'h00870000, 8'h01);
    prog(3'h3, 11'h009, 8'h0b, 32'h81008200, 8'h02);
    prog(3'h4, 11'h009, 8'h0f, 32'h00848200, 8'h03);
    // code 5 is outside the five effects and must act as none
    prog(3'h6, 11'h009, 8'h1e, 32'h00008800, 8'h05);
    prog(3'h5, 11'h00c, 8'h05, 32'h00000086, 8'h14);
    apb(1'b0, `ASL_OFF_LAMPS, 32'h0);
    chk("lamps readback", rd, 32'h00000086);
    apb(1'b0, `ASL_OFF_SEL, 32'h0);
    chk("sel readback", rd, 32'h00000005);
    apb(1'b0, `ASL_OFF_KEY, 32'h0);
    chk("key readback", rd, 32'h8005000c);
    apb(1'b0, `ASL_OFF_FX, 32'h0);
    chk("fx readback", rd, 32'h00000014);
    $display("registers finished");
    cmd_source_model_inst.send(11'h009, 8'h1d);
    tick(3);
    chk("none lamps", 32'(lamp_o), 32'h0008);
    cmd_source_model_inst.send(11'h00a, 8'h1d);
    tick(3);
    chk("no match kept", 32'(lamp_o), 32'h0008);
    cmd_source_model_inst.send(11'h009, 8'h00);
    tick(3);
    chk("none slot d", 32'(lamp_o), 32'h0020);
    $display("none finished");
    cmd_source_model_inst.send(11'h009, 8'h15);
    tick(400);
    c5 = 0;
    c7 = 0;
    repeat (64) begin
      @(posedge clk_i);
      #1;
      c5 += int'(lamp_o[5]);
      c7 += int'(lamp_o[7]);
    end
    chk("fade both part lit", 32'(c5 > 0 && c5 < 64 && c7 > 0 && c7 < 64), 32'h1);
    tick(1000);
    chk("fade end", 32'(lamp_o), 32'h0080);
    $display("fade finished");
    cmd_source_model_inst.send(11'h009, 8'h0b);
    tick(3);
    chk("tumble busy", 32'(busy_o), 32'h1);
    chk("tumble no jump", 32'(lamp_o[2]), 32'h0);
    apb(1'b0, `ASL_OFF_STATUS, 32'h0);
    chk("tumble mid target", rd[15:0], 16'h0304);
    tick(1200);
    chk("tumble mid lamp", 32'(lamp_o), 32'h0004);
    tick(500);
    chk("tumble done", 32'(busy_o), 32'h0);
    apb(1'b0, `ASL_OFF_STATUS, 32'h0);
    chk("tumble final target", rd[7:0], 8'h02);
    tick(1100);
    chk("tumble final lamp", 32'(lamp_o), 32'h0002);
    $display("tumble finished");
    cmd_source_model_inst.send(11'h009, 8'h1e);
    tick(3);
    chk("unknown code lamps", 32'(lamp_o), 32'h0100);
    chk("unknown code idle", 32'(busy_o), 32'h0);
    $display("unknown code finished");
    cmd_source_model_inst.send(11'h009, 8'h0f);
    tick(3);
    chk("flash mid lamp", 32'(lamp_o), 32'h0004);
    chk("flash busy", 32'(busy_o), 32'h1);
    tick(300);
    chk("flash done", 32'(busy_o), 32'h0);
    chk("flash final", 32'(lamp_o), 32'h0010);
    $display("filter flash finished");
    apb(1'b1, `ASL_OFF_FLASH, 32'h0000000a);
    cmd_source_model_inst.send(11'h00c, 8'h05);
    tick(20);
    // two whole periods give a count free of the phase
    strobe_count(2 * 10 * TK);
    apb(1'b1, `ASL_OFF_FLASH, 32'h00000014);
    strobe_count(2 * 20 * TK);
    $display("strobe finished");
    wrap_up;
  end

  initial begin
    #600000;
    miscompares++;
    wrap_up;
  end
endmodule // testbench
